// ---- bench/dma_ahb_access_arbiter_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Self-checking bench of the DMA access arbiter.
// ****************************************************************
module dma_ahb_access_arbiter_tb_top;
  logic                      core_clk;   // Core clock.
  logic                      sys_rst;    // Reset, active high.
  dmaarb_pkg::dmaarb_bus_t   bus;        // Register port request.
  logic [31:0]               reg_rdata;  // Register read data.
  logic [3:0]                chan_req;   // Requests from the model.
  logic [3:0]                chan_gnt;   // Grants from the arbiter.
  logic [3:0]                start;      // Model start commands.
  logic                      stop;       // Model stop command.
  logic [7:0]                hold_len;   // Owned cycles per request.
  logic [3:0]                gnt_prev;   // Grant of the last cycle.
  logic [15:0]               ord_q;      // Winners in order, one-hot.
  int                        n_grants;   // Grants seen since cleared.
  int                        num_errors; // Mismatches.
  int                        n_tests;    // Comparisons.
  logic [31:0]               rd_v;       // Last read value.
  logic                      clr_log;    // Clears the winner log at the next edge.

  dmaarb_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_bus(bus),
    .reg_rdata(reg_rdata), .chan_req(chan_req), .chan_gnt(chan_gnt));

  dmaarb_chan_model chan_u (.core_clk(core_clk), .sys_rst(sys_rst), .start(start),
    .stop(stop), .hold_len(hold_len), .chan_gnt(chan_gnt), .chan_req(chan_req));

  // ****************************************************************
  // Checking and bus tasks.
  // ****************************************************************
  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // A spare edge closes each access so no strobe is driven twice at once.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    @(posedge core_clk);
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] a);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
    @(posedge core_clk);
  endtask : reg_rd

  // Bounded waits; running out is a mismatch and ends the run.
  task automatic wait_grants(input int n);
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (n_grants >= n) begin
        return;
      end
    end
    num_errors++;
    give_verdict();
  endtask : wait_grants

  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if ((chan_gnt | (chan_req & 4'h5)) === 4'h0) begin
        return;
      end
    end
    num_errors++;
    give_verdict();
  endtask : wait_idle

  // Pulses a start command to the channel model for one cycle.
  task automatic kick(input logic [3:0] m);
    start <= m;
    @(posedge core_clk);
    start <= 4'h0;
  endtask : kick

  // ****************************************************************
  // Grant watcher.
  // ****************************************************************
  // Every cycle: at most one owner, never an absent channel, and each new
  // owner is logged so the scenarios can judge the order of winners.
  // The log has this one writer; scenarios ask for a clear through clr_log.
  always @(posedge core_clk) begin
    if (!sys_rst) begin
      check("grant one hot", {31'h0, $onehot0(chan_gnt)}, 32'h1);
      check("absent grant", {28'h0, chan_gnt & 4'hA}, 32'h0);
    end
    if (clr_log) begin
      ord_q    <= 16'h0;
      n_grants <= 0;
    end else if (!sys_rst && chan_gnt !== 4'h0 && gnt_prev === 4'h0) begin
      ord_q    <= {ord_q[11:0], chan_gnt};
      n_grants <= n_grants + 1;
    end
    gnt_prev <= chan_gnt;
  end

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // Two rounds of read 0 and write 0 asking together; extra adds absent askers.
  task automatic run_order(input logic [31:0] word, input logic [3:0] extra);
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h0);
    reg_wr(dmaarb_pkg::OFS_SETTINGS, word);
    clr_log  <= 1'b1;
    hold_len <= 8'h03;
    kick(4'h5 | extra);
    clr_log  <= 1'b0;
    wait_grants(2);
    wait_idle();
    kick(4'h5);
    wait_grants(4);
    wait_idle();
    kick(4'h0);
    stop <= 1'b1;
    @(posedge core_clk);
    stop <= 1'b0;
  endtask : run_order

  // Settings writes, refusal, locking and the read-only or unmapped places.
  task automatic scen_regs();
    reg_rd(dmaarb_pkg::OFS_SETTINGS);
    check("settings reset", rd_v, 32'h0);
    reg_rd(8'h08);
    check("unmapped read", rd_v, 32'h0);
    // Equal ranks everywhere, then equal ranks only on absent channels.
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h80000000);
    reg_rd(dmaarb_pkg::OFS_SETTINGS);
    check("enable refused", rd_v, 32'h0);
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h80000201);
    reg_rd(dmaarb_pkg::OFS_SETTINGS);
    check("absent ranks equal", rd_v, 32'h00000201);
    reg_rd(dmaarb_pkg::OFS_STATUS);
    check("refused flag", rd_v, 32'h00000100);
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h80003102);
    reg_rd(dmaarb_pkg::OFS_SETTINGS);
    check("enable taken", rd_v, 32'h80003102);
    reg_rd(dmaarb_pkg::OFS_STATUS);
    check("refused cleared", rd_v, 32'h0);
    // Mode and ranks are locked while enabled; other places ignore writes.
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h90000213);
    reg_wr(dmaarb_pkg::OFS_STATUS, 32'hFFFFFFFF);
    reg_wr(8'h08, 32'hFFFFFFFF);
    reg_rd(dmaarb_pkg::OFS_SETTINGS);
    check("locked fields", rd_v, 32'h80003102);
    reg_rd(dmaarb_pkg::OFS_STATUS);
    check("status read only", rd_v, 32'h0);
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h0);
  endtask : scen_regs

  // A request while disabled is never served.
  task automatic scen_blocked();
    hold_len <= 8'h03;
    kick(4'h1);
    repeat (6) @(posedge core_clk);
    check("grant while disabled", {28'h0, chan_gnt}, 32'h0);
    stop <= 1'b1;
    @(posedge core_clk);
    stop <= 1'b0;
  endtask : scen_blocked

  // Grant one cycle after the request, dropped when the arbiter is disabled.
  task automatic scen_midgrant();
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h80003102);
    hold_len <= 8'h00;
    kick(4'h1);
    #1;
    check("grant too early", {28'h0, chan_gnt}, 32'h0);
    @(posedge core_clk);
    #1;
    check("grant latency", {28'h0, chan_gnt}, 32'h1);
    @(posedge core_clk);
    reg_wr(dmaarb_pkg::OFS_SETTINGS, 32'h0);
    #1;
    check("grant after disable", {28'h0, chan_gnt}, 32'h0);
    stop <= 1'b1;
    @(posedge core_clk);
    stop <= 1'b0;
  endtask : scen_midgrant

  // ****************************************************************
  // Clock, reset and main sequence.
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    bus        = '0;
    start      = 4'h0;
    stop       = 1'b0;
    hold_len   = 8'h03;
    clr_log    = 1'b1;
    num_errors = 0;
    n_tests    = 0;
    sys_rst    = 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    clr_log <= 1'b0;
    scen_regs();
    scen_blocked();
    // Round robin ignores ranks that favour write 0.
    run_order(32'h80003102, 4'h0);
    check("round robin order", {16'h0, ord_q}, 32'h00001414);
    // Fixed mode: write 0 ranks 01 and wins; absent read 1 ranks 00 and asks.
    run_order(32'h90003102, 4'hA);
    check("fixed order write", {16'h0, ord_q}, 32'h00004141);
    run_order(32'h90003201, 4'hA);
    check("fixed order read", {16'h0, ord_q}, 32'h00001414);
    scen_midgrant();
    give_verdict();
  end
endmodule : dma_ahb_access_arbiter_tb_top

`default_nettype wire

// ---- bench/dmaarb_chan_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Model of the DMA channels that ask the arbiter for the AHB bus.
// ****************************************************************
module dmaarb_chan_model (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Commands from the bench.
  input  wire logic [3:0] start,
  input  wire logic       stop,
  input  wire logic [7:0] hold_len,
  // Arbiter side.
  input  wire logic [3:0] chan_gnt,
  output logic      [3:0] chan_req
);
  // Owned cycles still to go for each channel.
  logic [7:0] left_q [4];

  // A channel asks on command and keeps asking until it has owned the
  // bus for hold_len cycles; a hold of zero wraps, so it asks for long.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_req <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        left_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (stop) begin
          chan_req[i] <= 1'b0;
        end else if (start[i]) begin
          chan_req[i] <= 1'b1;
          left_q[i]   <= hold_len;
        end else if (chan_req[i] && chan_gnt[i]) begin
          // The request falls only once the owned cycles are used up.
          if (left_q[i] == 8'h01) begin
            chan_req[i] <= 1'b0;
          end
          left_q[i] <= left_q[i] - 8'h01;
        end
      end
    end
  end
endmodule : dmaarb_chan_model

`default_nettype wire

// ---- hw/dmaarb_fix_pick.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Fixed-priority picker: the requester with the smallest field wins.
// ****************************************************************
module dmaarb_fix_pick #(
  parameter int unsigned N = 4
) (
  // Requests and their programmed ranks.
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0][1:0] prio,
  // Result.
  output logic                   found,
  output logic [$clog2(N)-1:0]   win
);

  // Ranks are unique while enabled; a tie would fall to the lower index.
  always_comb begin
    logic [1:0] best;
    best  = 2'h3;
    found = 1'b0;
    win   = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || prio[i] < best)) begin
        found = 1'b1;
        best  = prio[i];
        win   = i[$clog2(N)-1:0];
      end
    end
  end

endmodule : dmaarb_fix_pick
`default_nettype wire

// ---- hw/dmaarb_pkg.sv ----

// ****************************************************************
// Shared constants and types of the DMA arbiter.
// ****************************************************************
package dmaarb_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_SETTINGS = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;

  // Field positions in the settings register.
  localparam int unsigned EN_BIT      = 31;
  localparam int unsigned MODE_BIT    = 28;
  localparam int unsigned PRIO_R0_LSB = 0;
  localparam int unsigned PRIO_R1_LSB = 4;
  localparam int unsigned PRIO_W0_LSB = 8;
  localparam int unsigned PRIO_W1_LSB = 12;
  localparam int unsigned PRIO_W      = 2;

  // Field positions in the status register.
  localparam int unsigned STAT_GNT_LSB = 0;
  localparam int unsigned STAT_REF_BIT = 8;

  // Channel indices; index i also selects priority field i.
  localparam int unsigned NCHAN  = 4;
  localparam int unsigned CH_R0  = 0;
  localparam int unsigned CH_R1  = 1;
  localparam int unsigned CH_W0  = 2;
  localparam int unsigned CH_W1  = 3;

  // Only the first read and first write channel are built.
  localparam logic [3:0] CHAN_PRESENT = 4'h5;

  // Reset values.
  localparam logic       RST_EN   = 1'h0;
  localparam logic       RST_MODE = 1'h0;
  localparam logic [1:0] RST_PRIO = 2'h0;
  localparam logic [1:0] RST_LAST = 2'h3;

  // Arbitration modes.
  localparam logic MODE_RR  = 1'h0;
  localparam logic MODE_FIX = 1'h1;

  // One register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dmaarb_bus_t;

  // Settings held by the arbiter.
  typedef struct packed {
    logic       en;
    logic       mode;
    logic [3:0][1:0] prio;
  } dmaarb_set_t;

  // Grant controller states.
  typedef enum logic {ST_IDLE, ST_OWNED} dmaarb_state_t;

  // Bit position of priority field i in the settings word.
  function automatic int unsigned prio_lsb(input int unsigned i);
    case (i)
      CH_R0:   prio_lsb = PRIO_R0_LSB;
      CH_R1:   prio_lsb = PRIO_R1_LSB;
      CH_W0:   prio_lsb = PRIO_W0_LSB;
      default: prio_lsb = PRIO_W1_LSB;
    endcase
  endfunction : prio_lsb

endpackage : dmaarb_pkg

// ---- hw/dmaarb_rr_pick.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Round-robin picker: searches from the channel after the last winner.
// ****************************************************************
module dmaarb_rr_pick #(
  parameter int unsigned N = 4
) (
  // Requests and history.
  input  wire logic [N-1:0]         req,
  input  wire logic [$clog2(N)-1:0] last,
  // Result.
  output logic                      found,
  output logic [$clog2(N)-1:0]      win
);

  // The last winner is tried last, so it sits at lowest precedence.
  always_comb begin
    logic [$clog2(N)-1:0] idx;
    idx   = '0;
    found = 1'b0;
    win   = '0;
    for (int k = 1; k <= N; k++) begin
      idx = last + k[$clog2(N)-1:0];
      if (!found && req[idx]) begin
        found = 1'b1;
        win   = idx;
      end
    end
  end

endmodule : dmaarb_rr_pick
`default_nettype wire

// ---- hw/dmaarb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// DMA access arbiter of the USB core AHB bridge.
// ****************************************************************
module dmaarb_top (
  // Clock and reset.
  input  wire logic                            core_clk,
  input  wire logic                            sys_rst,
  // Register port.
  input  wire dmaarb_pkg::dmaarb_bus_t         reg_bus,
  output logic [dmaarb_pkg::DATA_W-1:0]        reg_rdata,
  // DMA channel requests, held until the channel's transfer is done.
  input  wire logic [dmaarb_pkg::NCHAN-1:0]    chan_req,
  // One-hot AHB ownership grant.
  output logic [dmaarb_pkg::NCHAN-1:0]         chan_gnt
);

  // ****************************************************************
  // Register state.
  // ****************************************************************

  dmaarb_pkg::dmaarb_set_t     set_q;        // Settings register contents.
  dmaarb_pkg::dmaarb_set_t     set_d;        // Settings after this cycle.
  logic                        refused_q;    // Last settings write asked for enable and was refused.
  logic                        refused_d;    // Next value of the refusal flag.
  logic [dmaarb_pkg::DATA_W-1:0] rdata_q;    // Registered read data.
  logic [dmaarb_pkg::DATA_W-1:0] rdata_d;    // Read data for next cycle.

  // ****************************************************************
  // Arbitration state.
  // ****************************************************************

  dmaarb_pkg::dmaarb_state_t   state_q;      // Grant controller state.
  dmaarb_pkg::dmaarb_state_t   state_d;      // Its next value.
  logic [dmaarb_pkg::NCHAN-1:0] gnt_q;       // Current grant, one-hot.
  logic [dmaarb_pkg::NCHAN-1:0] gnt_d;       // Next grant.
  logic [1:0]                  owner_q;      // Index of the current owner.
  logic [1:0]                  owner_d;      // Its next value.
  logic [1:0]                  last_q;       // Most recently finished winner.
  logic [1:0]                  last_d;       // Its next value.

  // ****************************************************************
  // Register decode.
  // ****************************************************************

  wire logic                   hit_set;      // Access to the settings word.
  wire logic                   hit_stat;     // Access to the status word.
  wire logic                   wr_set;       // Write to the settings word.
  wire logic [3:0][1:0]        wr_prio;      // Priorities carried by a write.
  wire logic [3:0][1:0]        cand_prio;    // Priorities standing after a write.
  wire logic                   cand_mode;    // Mode standing after a write.
  wire logic                   dup;          // Two candidate fields are equal.
  wire logic                   want_en;      // Write asks for enable.
  wire logic [dmaarb_pkg::DATA_W-1:0] set_word;  // Settings as read.
  wire logic [dmaarb_pkg::DATA_W-1:0] stat_word; // Status as read.

  assign hit_set  = (reg_bus.addr == dmaarb_pkg::OFS_SETTINGS);
  assign hit_stat = (reg_bus.addr == dmaarb_pkg::OFS_STATUS);
  assign wr_set   = reg_bus.wr && hit_set;
  assign want_en  = reg_bus.wdata[dmaarb_pkg::EN_BIT];

  // Field slicing repeats per channel, so it is a generate loop.
  // Absent channels keep a real field: it is stored and checked, never used to grant.
  for (genvar i = 0; i < dmaarb_pkg::NCHAN; i++) begin : g_field
    localparam int unsigned LSB = dmaarb_pkg::prio_lsb(i);
    assign wr_prio[i]   = reg_bus.wdata[LSB +: dmaarb_pkg::PRIO_W];
    // While enabled the fields are frozen, so the check uses the stored ones.
    assign cand_prio[i] = set_q.en ? set_q.prio[i] : wr_prio[i];
  end

  assign cand_mode = set_q.en ? set_q.mode : reg_bus.wdata[dmaarb_pkg::MODE_BIT];

  // Any pair of equal fields blocks enabling, whatever the mode.
  assign dup = (cand_prio[0] == cand_prio[1]) || (cand_prio[0] == cand_prio[2]) ||
               (cand_prio[0] == cand_prio[3]) || (cand_prio[1] == cand_prio[2]) ||
               (cand_prio[1] == cand_prio[3]) || (cand_prio[2] == cand_prio[3]);

  // Read views; undefined bits read as zero.
  // Bits 27-14 are one blank run, so no further pad stands before write one.
  assign set_word = {set_q.en, 2'h0, set_q.mode, 14'h0000,
                     set_q.prio[dmaarb_pkg::CH_W1], 2'h0, set_q.prio[dmaarb_pkg::CH_W0],
                     2'h0, set_q.prio[dmaarb_pkg::CH_R1], 2'h0, set_q.prio[dmaarb_pkg::CH_R0]};
  assign stat_word = {23'h000000, refused_q, 4'h0, gnt_q};

  // ****************************************************************
  // Next settings: mode and ranks move only while disabled.
  // ****************************************************************

  always_comb begin
    set_d     = set_q;
    refused_d = refused_q;
    if (wr_set) begin
      set_d.mode = cand_mode;
      set_d.prio = cand_prio;
      // A request for enable with clashing ranks leaves the arbiter off.
      set_d.en   = want_en && !dup;
      refused_d  = want_en && dup;
    end
  end

  // Read data: unmapped addresses and idle cycles answer zero.
  assign rdata_d = !reg_bus.rd ? '0 :
                   hit_set      ? set_word :
                   hit_stat     ? stat_word : '0;

  // Settings, refusal flag and read data register.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      set_q.en   <= dmaarb_pkg::RST_EN;
      set_q.mode <= dmaarb_pkg::RST_MODE;
      set_q.prio <= {dmaarb_pkg::NCHAN{dmaarb_pkg::RST_PRIO}};
      refused_q  <= 1'b0;
      rdata_q    <= '0;
    end else begin
      set_q      <= set_d;
      refused_q  <= refused_d;
      rdata_q    <= rdata_d;
    end
  end

  // ****************************************************************
  // Winner selection.
  // ****************************************************************

  wire logic [3:0] req_live;   // Requests of built channels only.
  wire logic       rr_found;   // Round-robin picker saw a request.
  wire logic [1:0] rr_win;     // Round-robin winner.
  wire logic       fx_found;   // Fixed picker saw a request.
  wire logic [1:0] fx_win;     // Fixed winner.
  wire logic       any_found;  // Some built channel is requesting.
  wire logic [1:0] win;        // Winner for the current mode.

  // Unbuilt channels are masked so a stray input can never win.
  assign req_live = chan_req & dmaarb_pkg::CHAN_PRESENT;

  dmaarb_rr_pick #(
    .N     (dmaarb_pkg::NCHAN)
  ) u_rr (
    .req   (req_live),
    .last  (last_q),
    .found (rr_found),
    .win   (rr_win)
  );

  dmaarb_fix_pick #(
    .N     (dmaarb_pkg::NCHAN)
  ) u_fix (
    .req   (req_live),
    .prio  (set_q.prio),
    .found (fx_found),
    .win   (fx_win)
  );

  // The mode bit picks the policy; round-robin never looks at ranks.
  assign any_found = (set_q.mode == dmaarb_pkg::MODE_FIX) ? fx_found : rr_found;
  assign win       = (set_q.mode == dmaarb_pkg::MODE_FIX) ? fx_win : rr_win;

  // ****************************************************************
  // Grant controller.
  // ****************************************************************

  // A grant lasts while its channel keeps requesting and the arbiter stays enabled; either drop ends it.
  always_comb begin
    state_d = state_q;
    gnt_d   = gnt_q;
    owner_d = owner_q;
    last_d  = last_q;
    case (state_q)
      dmaarb_pkg::ST_IDLE: begin
        gnt_d = '0;
        if (set_q.en && any_found) begin
          state_d = dmaarb_pkg::ST_OWNED;
          owner_d = win;
          gnt_d   = 4'h1 << win;
        end
      end
      dmaarb_pkg::ST_OWNED: begin
        // Disabling withdraws the bus at once, even mid-transfer.
        if (!set_q.en || !req_live[owner_q]) begin
          state_d = dmaarb_pkg::ST_IDLE;
          gnt_d   = '0;
          last_d  = owner_q;
        end
      end
      default: begin
        state_d = dmaarb_pkg::ST_IDLE;
        gnt_d   = '0;
      end
    endcase
  end

  // Arbitration registers.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= dmaarb_pkg::ST_IDLE;
      gnt_q   <= '0;
      owner_q <= 2'h0;
      last_q  <= dmaarb_pkg::RST_LAST;
    end else begin
      state_q <= state_d;
      gnt_q   <= gnt_d;
      owner_q <= owner_d;
      last_q  <= last_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign chan_gnt  = gnt_q;
  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // A disabled arbiter holds no grant one cycle on.
  a_no_grant_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !set_q.en |=> (gnt_q == '0))
    else $error("grant present while arbiter disabled");

  // Never two owners.
  a_grant_onehot: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $onehot0(gnt_q))
    else $error("more than one channel granted");

  // Writes while enabled leave mode and ranks alone.
  a_lock_fields: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (wr_set && set_q.en) |=> ($stable(set_q.mode) && $stable(set_q.prio)))
    else $error("locked field changed while enabled");

  // Clashing ranks refuse the enable.
  a_refuse_dup: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (wr_set && !set_q.en && want_en && dup) |=> (!set_q.en && refused_q))
    else $error("enable accepted with equal priorities");

  // Unbuilt channels never own the bus.
  a_absent_idle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (gnt_q[dmaarb_pkg::CH_R1] == 1'b0) && (gnt_q[dmaarb_pkg::CH_W1] == 1'b0))
    else $error("absent channel granted");

  // Fixed mode gives the bus to read 0 when both ask and read 0 has the better rank.
  a_fixed_rank: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == dmaarb_pkg::ST_IDLE && set_q.en && set_q.mode == dmaarb_pkg::MODE_FIX &&
     req_live[dmaarb_pkg::CH_R0] && req_live[dmaarb_pkg::CH_W0] &&
     set_q.prio[dmaarb_pkg::CH_R0] < set_q.prio[dmaarb_pkg::CH_W0])
    |=> gnt_q[dmaarb_pkg::CH_R0])
    else $error("fixed priority picked the lower rank");

  // Round-robin hands over to read 0 when it asks after a finished grant of write 0.
  a_rr_rotate: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == dmaarb_pkg::ST_IDLE && set_q.en && set_q.mode == dmaarb_pkg::MODE_RR &&
     last_q == 2'(dmaarb_pkg::CH_W0) && req_live[dmaarb_pkg::CH_R0])
    |=> gnt_q[dmaarb_pkg::CH_R0])
    else $error("round robin regranted the last winner");

  // An enabled idle arbiter grants a request on the next edge.
  a_grant_soon: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_q == dmaarb_pkg::ST_IDLE && set_q.en && req_live != '0) |=> (gnt_q != '0))
    else $error("enabled request not granted");

  // Settings read back in the cycle after the read strobe.
  a_read_back: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_bus.rd && hit_set) |=> (reg_rdata == $past(set_word)))
    else $error("settings read data wrong");

endmodule : dmaarb_top
`default_nettype wire
